// ==== cmh_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : Shared constants for the CAN mode handshake and bit timing block
// Assumes : APB with 32-bit data, one register per aligned word
// Notes   : Register indices are word indices; byte address is index * 4
//////////////////////////////////////////////////////////////////////////////
package cmh_pkg;
  // Register word indices
  localparam logic [5:0] IDX_CTL0     = 6'h00; // Requests and wakeup enable
  localparam logic [5:0] IDX_STAT     = 6'h01; // Acknowledge flags, read only
  localparam logic [5:0] IDX_BT0      = 6'h02; // Bit timing zero
  localparam logic [5:0] IDX_BT1      = 6'h03; // Bit timing one
  localparam logic [5:0] IDX_CTL1     = 6'h04; // Control register one
  localparam logic [5:0] IDX_ACC_CTL  = 6'h05; // Acceptance control
  localparam logic [5:0] IDX_ACC_CODE = 6'h06; // First of eight code regs
  localparam logic [5:0] IDX_ACC_MASK = 6'h0E; // First of eight mask regs
  localparam logic [5:0] IDX_LAST     = 6'h15; // Highest mapped index
  localparam int         ACC_REGS     = 8;     // Code and mask regs each
  // Field positions
  localparam int CTL0_INIT_REQ  = 0;
  localparam int CTL0_SLEEP_REQ = 1;
  localparam int CTL0_WAKE_EN   = 2;
  localparam int STAT_INIT_ACK  = 0;
  localparam int STAT_SLEEP_ACK = 1;
  localparam int BT0_SJW_HI     = 7;
  localparam int BT0_SJW_LO     = 6;
  localparam int BT0_BRP_HI     = 5;
  // Reset values
  localparam logic [7:0] REG_RST  = 8'h00;
  localparam logic [2:0] CTL0_RST = 3'h0;
  // Default prescaler field width
  localparam int BRP_BITS = 6;
endpackage : cmh_pkg

// ==== cmh_tq_prescaler.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : Time-quantum tick generator, divides pclk by prescale + 1
// Assumes : Prescale value changes only while the controller is initialising
// Notes   : One-cycle tick; code zero ticks every cycle
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module cmh_tq_prescaler #(
  parameter int BRP_W = cmh_pkg::BRP_BITS
) (
  input  wire logic             pclk,    // Module clock
  input  wire logic             presetn, // Async reset, active low
  input  wire logic [BRP_W-1:0] baud_prescaler,     // Divide by brp + 1
  output logic                  tq_tick  // One pulse per time quantum
);
  import cmh_pkg::*;

  logic [BRP_W-1:0] cnt_q;

  // Refuse a width the counter cannot serve
  if (BRP_W < 1) begin : g_chk
    $error("cmh_tq_prescaler: BRP_W must be at least 1");
  end

  // Terminal count at brp so the period is brp + 1 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (cnt_q >= baud_prescaler) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Tick comes from a flop so the consumer sees a clean pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_tick <= 1'b0;
    end else begin
      tq_tick <= (cnt_q >= baud_prescaler);
    end
  end
endmodule : cmh_tq_prescaler

// ==== cmh_mode_timing.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : CAN mode handshake, configuration write gating, bit timing zero
// Assumes : APB slave, zero wait states; can_rx is an asynchronous pin
// Notes   : Notes on behaviour below
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Sleep ack is 1 once asleep, 0 running; asleep means req and ack.
// - While asleep, bus activity clears sleep ack if wakeup is enabled.
// - Init ack is status bit 0, 1 once in init; init means req and ack.
// - Ctl one, timing and acceptance regs take writes only in init mode.
// - Bit timing zero sits at index 2, writable whenever init is active.
// - Bits 7-6 of bit timing zero give a jump width of 1 to 4 quanta.
// - Quantum clock is module clock divided by six-bit prescaler plus 1.
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module cmh_mode_timing #(
  parameter int BRP_W = cmh_pkg::BRP_BITS
) (
  input  wire logic             pclk,         // Module clock
  input  wire logic             presetn,      // Async reset, active low
  input  wire logic             psel,         // APB select
  input  wire logic             penable,      // APB access phase
  input  wire logic             pwrite,       // APB direction
  input  wire logic [7:0]       paddr,        // APB byte address
  input  wire logic [31:0]      pwdata,       // APB write data
  output logic      [31:0]      prdata,       // APB read data
  output logic                  pready,       // APB ready
  output logic                  pslverr,      // APB error, unmapped
  input  wire logic             can_rx,       // CAN receive pin
  output logic                  tq_tick,      // Time-quantum pulse
  output logic      [2:0]       sjw_quanta,   // Jump width in quanta
  output logic                  init_active,  // Init mode active
  output logic                  sleep_active, // Sleep mode active
  output logic                  wakeup_event  // Bus wakeup pulse
);
  import cmh_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [2:0]       ctl0_q;
  logic             init_ack_q;
  logic             sleep_ack_q;
  logic             wake_hold_q;
  logic             rx_meta_q;
  logic             rx_sync_q;
  logic [7:0]       bt0_q;
  logic [7:0]       bt1_q;
  logic [7:0]       ctl1_q;
  logic [7:0]       acc_ctl_q;
  logic [7:0]       acc_code_q [ACC_REGS];
  logic [7:0]       acc_mask_q [ACC_REGS];
  logic [5:0]       idx;
  logic             wr_en;
  logic             cfg_wr_ok;
  logic             mapped;
  logic             bus_wake;
  logic             init_req;
  logic             sleep_req;
  logic             wake_en;
  logic [BRP_W-1:0] baud_prescaler;

  if (BRP_W < 1 || BRP_W > BT0_BRP_HI + 1) begin : g_chk
    $error("cmh_mode_timing: BRP_W must be 1 to 6");
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus decode; zero wait states so pready is always high
  assign idx       = paddr[7:2];
  assign mapped    = (idx <= IDX_LAST);
  assign wr_en     = psel & penable & pwrite & mapped;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;
  assign init_req  = ctl0_q[CTL0_INIT_REQ];
  assign sleep_req = ctl0_q[CTL0_SLEEP_REQ];
  assign wake_en   = ctl0_q[CTL0_WAKE_EN];
  // Mode states are the AND of request and ack
  assign init_active  = init_req & init_ack_q;
  assign sleep_active = sleep_req & sleep_ack_q;
  assign cfg_wr_ok    = wr_en & init_active;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= can_rx;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Dominant level while asleep counts as bus activity
  assign bus_wake = sleep_active & wake_en & ~rx_sync_q;

  //////////////////////////////////////////////////////////////////////////
  // Control zero is writable at any time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0_q <= CTL0_RST;
    end else if (wr_en && idx == IDX_CTL0) begin
      ctl0_q <= pwdata[2:0];
    end
  end

  // Init ack follows the request one cycle later, after entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_ack_q <= 1'b0;
    end else begin
      init_ack_q <= init_req;
    end
  end

  // Wake hold keeps a woken node from dropping straight back to sleep
  // until software withdraws the request; a wake wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_hold_q <= 1'b0;
    end else if (bus_wake) begin
      wake_hold_q <= 1'b1;
    end else if (!sleep_req) begin
      wake_hold_q <= 1'b0;
    end
  end

  // Sleep ack: set after entry, cleared on wakeup or withdrawal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_ack_q <= 1'b0;
    end else if (bus_wake) begin
      sleep_ack_q <= 1'b0;
    end else begin
      sleep_ack_q <= sleep_req & ~wake_hold_q;
    end
  end

  // Wakeup pulse to the protocol engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_event <= 1'b0;
    end else begin
      wakeup_event <= bus_wake;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Protected configuration registers; writes outside init are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bt0_q     <= REG_RST;
      bt1_q     <= REG_RST;
      ctl1_q    <= REG_RST;
      acc_ctl_q <= REG_RST;
    end else if (cfg_wr_ok) begin
      case (idx)
        IDX_BT0:     bt0_q     <= pwdata[7:0];
        IDX_BT1:     bt1_q     <= pwdata[7:0];
        IDX_CTL1:    ctl1_q    <= pwdata[7:0];
        IDX_ACC_CTL: acc_ctl_q <= pwdata[7:0];
        default:     ;
      endcase
    end
  end

  // Acceptance code and mask banks, one entry per index
  for (genvar i = 0; i < ACC_REGS; i++) begin : g_acc
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc_code_q[i] <= REG_RST;
        acc_mask_q[i] <= REG_RST;
      end else if (cfg_wr_ok) begin
        if (idx == IDX_ACC_CODE + 6'(i)) begin
          acc_code_q[i] <= pwdata[7:0];
        end
        if (idx == IDX_ACC_MASK + 6'(i)) begin
          acc_mask_q[i] <= pwdata[7:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux over flop state; unmapped reads return zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (idx == IDX_CTL0) begin
      prdata[2:0] = ctl0_q;
    end else if (idx == IDX_STAT) begin
      prdata[STAT_INIT_ACK]  = init_ack_q;
      prdata[STAT_SLEEP_ACK] = sleep_ack_q;
    end else if (idx == IDX_BT0) begin
      prdata[7:0] = bt0_q;
    end else if (idx == IDX_BT1) begin
      prdata[7:0] = bt1_q;
    end else if (idx == IDX_CTL1) begin
      prdata[7:0] = ctl1_q;
    end else if (idx == IDX_ACC_CTL) begin
      prdata[7:0] = acc_ctl_q;
    end else if (idx >= IDX_ACC_CODE && idx < IDX_ACC_MASK) begin
      prdata[7:0] = acc_code_q[3'(idx - IDX_ACC_CODE)];
    end else if (idx >= IDX_ACC_MASK && idx <= IDX_LAST) begin
      prdata[7:0] = acc_mask_q[3'(idx - IDX_ACC_MASK)];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Timing outputs: jump width code plus one, prescaler from low bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sjw_quanta <= 3'h1;
    end else begin
      sjw_quanta <= {1'b0, bt0_q[BT0_SJW_HI:BT0_SJW_LO]} + 3'h1;
    end
  end

  assign baud_prescaler = bt0_q[BRP_W-1:0];

  cmh_tq_prescaler #(.BRP_W(BRP_W)) u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .baud_prescaler     (baud_prescaler),
    .tq_tick (tq_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // Helper: cycles since last tick, valid once a full period is seen
  logic [7:0] gap_q;
  logic       gap_ok_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q    <= 8'h00;
      gap_ok_q <= 1'b0;
    end else if (cfg_wr_ok) begin
      gap_q    <= 8'h00;
      gap_ok_q <= 1'b0;
    end else if (tq_tick) begin
      gap_q    <= 8'h00;
      gap_ok_q <= 1'b1;
    end else begin
      gap_q    <= gap_q + 8'h01;
    end
  end

  // Checks
  sleep_ack_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(sleep_ack_q) |-> $past(sleep_req))
    else $error("sleep ack rose without request");
  sleep_run_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !sleep_req |=> !sleep_ack_q && !sleep_active)
    else $error("sleep ack high while running");
  wake_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus_wake |=> !sleep_ack_q && wakeup_event)
    else $error("wakeup did not clear sleep ack");
  init_stat_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && idx == IDX_STAT |-> prdata[0] == init_ack_q)
    else $error("init ack not in status bit 0");
  prot_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && !init_active && idx >= IDX_BT0
    |=> $stable(bt0_q) && $stable(bt1_q) && $stable(ctl1_q))
    else $error("protected write outside init mode");
  bt0_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && init_active && idx == IDX_BT0
    |=> bt0_q == $past(pwdata[7:0]))
    else $error("bit timing zero write lost");
  sjw_width_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 sjw_quanta == {1'b0, $past(bt0_q[7:6])} + 3'h1)
    else $error("jump width decode wrong");
  tq_period_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tq_tick && gap_ok_q |-> gap_q == 8'(baud_prescaler))
    else $error("quantum period wrong");
  ack_drop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(init_req) |-> ##[0:1] !init_ack_q)
    else $error("init ack stuck after withdrawal");

  init_enter_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(init_active));
  sleep_wake_c: cover property (@(posedge pclk) disable iff (!presetn)
    sleep_active ##[1:20] wakeup_event);
  bt0_set_c: cover property (@(posedge pclk) disable iff (!presetn)
    cfg_wr_ok && idx == IDX_BT0);
endmodule : cmh_mode_timing

// ==== cmh_bus_node.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : Remote CAN node as seen through the transceiver on can_rx
// Assumes : Bus idles recessive (1) through its termination
// Notes   : Drives a dominant burst of a given length when asked
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module cmh_bus_node (
  input  wire logic       pclk,    // Module clock
  input  wire logic       presetn, // Async reset, active low
  input  wire logic       send,    // Start a dominant burst
  input  wire logic [7:0] dom_len, // Burst length in cycles
  output logic            can_rx   // Receive pin level
);
  logic [7:0] left_q;
  // Burst counter; the line falls back to recessive when it runs out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) left_q <= 8'h00;
    else if (send) left_q <= dom_len;
    else if (left_q != 8'h00) left_q <= left_q - 8'h01;
  end
  // Dominant only while bursting, so idle never looks like activity
  assign can_rx = (left_q == 8'h00);
endmodule : cmh_bus_node

// ==== tb.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : Self-checking bench for the mode handshake and bit timing block
// Assumes : Zero-wait APB slave, registers one per aligned word
// Notes   : Each scenario is a task that judges its own results
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module tb;
  import cmh_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, can_rx, tq_tick, err;
  logic        init_active, sleep_active, wakeup_event;
  logic [2:0]  sjw_quanta;
  logic        send = 1'b0;
  logic [7:0]  dom_len = 8'h04;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          wake_count = 0;

  always #5 pclk = ~pclk;

  cmh_mode_timing #(.BRP_W(6)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_rx(can_rx), .tq_tick(tq_tick), .sjw_quanta(sjw_quanta),
    .init_active(init_active), .sleep_active(sleep_active),
    .wakeup_event(wakeup_event));
  cmh_bus_node node (.pclk(pclk), .presetn(presetn), .send(send),
    .dom_len(dom_len), .can_rx(can_rx));

  // Count wake pulses where they are settled, away from the clock edge
  always @(negedge pclk) if (wakeup_event === 1'b1) wake_count++;

  //////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task timeout;
    bad_count++;
    $display("MISMATCH at %0t: wait ran out", $time);
    print_verdict();
  endtask : timeout

  // One APB transfer; the answer is taken at the rising edge that sees
  // pready high, before that edge's register updates land
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int   n;
    logic ok;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    ok = 1'b0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge pclk);
      rd = prdata;
      err = pslverr;
      ok = (pready === 1'b1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!ok) timeout();
  endtask : apb

  // Poll the status word until a flag reaches a value
  task wait_ack(input int pos, input logic val);
    int n;
    for (n = 0; n < 20; n++) begin
      apb(1'b0, 8'h04, 32'h0);
      if (rd[pos] === val) return;
    end
    timeout();
  endtask : wait_ack

  task wait_tick(output int gap);
    gap = 0;
    do begin
      @(negedge pclk);
      gap++;
    end while (tq_tick !== 1'b1 && gap < 200);
    if (gap >= 200) timeout();
  endtask : wait_tick

  // First period after a change may be odd, so skip two
  task measure(input logic [5:0] baud_prescaler);
    int gap;
    apb(1'b1, 8'h08, {26'h0, baud_prescaler});
    repeat (3) wait_tick(gap);
    check(32'(gap), 32'(baud_prescaler) + 32'h1);
  endtask : measure

  task burst;
    @(posedge pclk);
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask : burst

  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    int i;
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd, 32'h0);
    end
    check({29'h0, sjw_quanta}, 32'h1);
    check({31'h0, init_active}, 32'h0);
    check({31'h0, sleep_active}, 32'h0);
  endtask : t_reset

  // Protected writes outside init mode must be dropped
  task t_locked;
    int i;
    for (i = 2; i <= 21; i++) apb(1'b1, 8'(i * 4), 32'hA5);
    for (i = 2; i <= 21; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd, 32'h0);
    end
  endtask : t_locked

  task t_init;
    int i;
    apb(1'b1, 8'h00, 32'h1);
    wait_ack(0, 1'b1);
    check({31'h0, init_active}, 32'h1);
    for (i = 2; i <= 21; i++) apb(1'b1, 8'(i * 4), 32'(8'h30 + i));
    for (i = 2; i <= 21; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd, 32'(8'h30 + i));
    end
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 8'h08, {24'h0, 2'(i), 6'h05});
      repeat (3) @(negedge pclk);
      check({29'h0, sjw_quanta}, 32'(i + 1));
    end
    measure(6'h00);
    measure(6'h01);
    measure(6'h3F);
    apb(1'b1, 8'h00, 32'h0);
    wait_ack(0, 1'b0);
    check({31'h0, init_active}, 32'h0);
    apb(1'b1, 8'h08, 32'hFF);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h3F);
  endtask : t_init

  // Bus activity wakes only when wakeup is enabled
  task t_sleep;
    apb(1'b1, 8'h00, 32'h2);
    wait_ack(1, 1'b1);
    check({31'h0, sleep_active}, 32'h1);
    wake_count = 0;
    burst();
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h2);
    check(32'(wake_count), 32'h0);
    apb(1'b1, 8'h00, 32'h6);
    burst();
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0);
    check(32'(wake_count), 32'h1);
    check({31'h0, sleep_active}, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
  endtask : t_sleep

  task t_unmapped;
    apb(1'b1, 8'h58, 32'h77);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h58, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    check({31'h0, err}, 32'h0);
  endtask : t_unmapped

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_locked();
    t_init();
    t_sleep();
    t_unmapped();
    print_verdict();
  end
endmodule : tb
